// ---- logic/tfm_map.vh ----
`ifndef TFM_MAP_VH
`define TFM_MAP_VH
// register byte offsets on the apb side
`define TFM_CTRL_OFF 8'h00
`define TFM_FIELD_OFF 8'h04
`define TFM_VALUE_OFF 8'h08
`define TFM_CHECK_OFF 8'h0C
`define TFM_TEXT_OFF 8'h10
`define TFM_XSTAT_OFF 8'h14
`define TFM_CSTAT_OFF 8'h18
`define TFM_LEN_OFF 8'h1C
`define TFM_AVG_OFF 8'h20
// control command bits
`define TFM_CTRL_FMT_BIT 0
`define TFM_CTRL_SEND_BIT 1
`define TFM_CTRL_CLR_BIT 2
// field descriptor layout
`define TFM_FLD_WID_GIVEN_BIT 20
`define TFM_FLD_DEC_GIVEN_BIT 21
`define TFM_FLD_FMT_GIVEN_BIT 22
`define TFM_FLD_FIXED_BIT 23
`define TFM_FIELD_MASK 32'h00F3FFFF
// text append layout
`define TFM_TEXT_HEX_BIT 16
// defaults for omitted parameters
`define TFM_DEF_WIDTH 4'h3
`define TFM_DEF_DEC 4'h0
`define TFM_DEF_FMT 2'h0
`define TFM_CHECK_IDX 8'h18
// extended status bit positions
`define TFM_XS_FAULT 0
`define TFM_XS_HCRIT 1
`define TFM_XS_HON 2
`define TFM_XS_STATIC 4
`define TFM_XS_FILL_LO 8
`define TFM_XS_RESTART 13
// timing
`define TFM_CLK_NS 100
`define TFM_SEC_NS 1000000000
`define TFM_SEC_CYCLES 24'h989680
`define TFM_NOVAL_S 4'hA
`define TFM_AVG_LIMIT_S 16'h000A
`define TFM_STATIC_S 7'h3C
// telegram buffer
`define TFM_BUF_DEPTH 7'h40
`define TFM_BUF_AW 6
`endif

// ---- logic/tfm_char_mem.v ----
`timescale 1ns/1ps
// telegram character buffer, one write port, one registered read port
module tfm_char_mem (
	clk_sys,
	wr_en,
	wr_addr,
	wr_data,
	rd_addr,
	rd_data
);
	input wire clk_sys;
	input wire wr_en;
	input wire [5:0] wr_addr;
	input wire [7:0] wr_data;
	input wire [5:0] rd_addr;
	output reg [7:0] rd_data;
	reg [7:0] mem [0:63]; // character storage, no reset needed
	// write and registered read; read of a location being written returns old data
	always @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule // tfm_char_mem

// ---- logic/tfm_formatter.v ----
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "tfm_map.vh"
// Summary of operation
// - integer field, no point, optional sign/hex
// - format code: bit0 signed, bit1 hex
// - emitted width equals width, sign included
// - omitted integer width 3, format 0
// - fixed-point adds decimal places parameter
// - fraction digits; point and sign counted
// - omitted fixed-point: width 3, 0, 0
// - index 24 makes XOR check field
// - positions from zero, start included
// - end position excluded, half-open range
// - short averaging: no value 10 s faults
// - long averaging: under half buffer faults
// - bit1 heat criterion, bit2 heater on
// - bit4 when fault exceeds one minute
// - bits 8-11 fill level in sixteenths
// - restart flag cleared by first telegram
// - condensed status derived from extended word
// - literal char given as two hex digits
module tfm_formatter #(
	parameter [23:0] SEC_CYCLES = `TFM_SEC_CYCLES
) (
	clk_sys,
	reset_n,
	psel,
	penable,
	pwrite,
	paddr,
	pwdata,
	prdata,
	pready,
	pslverr,
	new_value_pin,
	heat_crit_pin,
	heat_on_pin,
	tx_ready,
	tx_data,
	tx_valid
);
	input wire clk_sys;
	input wire reset_n; // synchronous, active low
	input wire psel;
	input wire penable;
	input wire pwrite;
	input wire [7:0] paddr;
	input wire [31:0] pwdata;
	output reg [31:0] prdata;
	output reg pready;
	output reg pslverr;
	input wire new_value_pin; // toggles high when a measurement completes
	input wire heat_crit_pin;
	input wire heat_on_pin;
	input wire tx_ready; // serial side accepts a character
	output reg [7:0] tx_data;
	output reg tx_valid;

	localparam S_IDLE = 5'b00001;
	localparam S_SCAN = 5'b00010;
	localparam S_CONV = 5'b00100;
	localparam S_EMIT = 5'b01000;
	localparam S_SEND = 5'b10000;

	reg [4:0] st_r; // engine state
	reg [31:0] field_r; // field descriptor
	reg [31:0] value_r; // measured value to render
	reg [14:0] check_r; // start [5:0], end [14:8]
	reg [31:0] avg_r; // averaging time [15:0], fill count [31:16]
	reg [6:0] len_r; // characters in telegram buffer
	reg [6:0] idx_r; // scan / send position
	reg pend_r; // read data due this cycle
	reg [7:0] xacc_r; // running xor
	reg [31:0] mag_r; // magnitude being digitised
	reg neg_r; // value negative
	reg [3:0] cnt_r; // character counter
	reg [3:0] wid_r;
	reg [3:0] dec_r;
	reg [1:0] fmt_r;
	reg fixed_r;
	reg load_r; // send read in flight
	reg restart_r; // restart flag
	reg [7:0] scr_r [0:15]; // rendered field, left to right
	reg [2:0] sync1_r; // pin synchroniser first stage
	reg [2:0] sync2_r; // pin synchroniser second stage
	reg nv_prev_r; // new value edge detect
	reg [23:0] sec_cnt_r; // one-second divider
	reg sec_tick_r; // one-cycle second enable
	reg [3:0] nv_sec_r; // seconds since last value
	reg [6:0] st_sec_r; // seconds in fault
	reg fault_r;
	reg static_r;
	reg [3:0] fill_r;
	reg [3:0] fill_nxt;
	integer k;

	wire [7:0] rd_data; // buffer read data
	wire acc = psel & penable; // apb access phase
	wire wr_take = acc & pready & pwrite; // write commits at completion edge
	wire idle = st_r[0];
	wire new_val = sync2_r[0] & ~nv_prev_r;
	wire [15:0] avg_time = avg_r[15:0];
	wire [15:0] avg_cnt = avg_r[31:16];

	// resolve omitted parameters to their defaults
	wire [3:0] eff_wid = field_r[`TFM_FLD_WID_GIVEN_BIT] ? field_r[11:8] : `TFM_DEF_WIDTH;
	wire [3:0] eff_dec = field_r[`TFM_FLD_DEC_GIVEN_BIT] ? field_r[15:12] : `TFM_DEF_DEC;
	wire [1:0] eff_fmt = field_r[`TFM_FLD_FMT_GIVEN_BIT] ? field_r[17:16] : `TFM_DEF_FMT;
	wire is_check = (field_r[7:0] == `TFM_CHECK_IDX);

	// text append, optionally from two ascii hex digits
	function [3:0] hex_val;
		input [7:0] c;
		begin
			if (c >= 8'h30 && c <= 8'h39) hex_val = c[3:0];
			else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) hex_val = c[3:0] + 4'h9;
			else hex_val = 4'h0;
		end
	endfunction
	wire [7:0] text_chr = pwdata[`TFM_TEXT_HEX_BIT] ?
		{hex_val(pwdata[15:8]), hex_val(pwdata[7:0])} : pwdata[7:0];
	wire room = (len_r < `TFM_BUF_DEPTH); // full buffer drops characters
	wire text_we = wr_take && paddr == `TFM_TEXT_OFF && idle && room;
	wire emit_we = st_r[3] && (cnt_r != wid_r) && room;
	wire mem_we = text_we | emit_we;
	wire [7:0] mem_wd = text_we ? text_chr : scr_r[cnt_r];

	tfm_char_mem u_mem (
		.clk_sys(clk_sys),
		.wr_en(mem_we),
		.wr_addr(len_r[5:0]),
		.wr_data(mem_wd),
		.rd_addr(idx_r[5:0]),
		.rd_data(rd_data)
	);

	// digit generation for the current position
	wire [3:0] pos = wid_r - 4'h1 - cnt_r; // filled right to left
	wire [3:0] pt_pos = wid_r - 4'h1 - dec_r;
	wire [31:0] dec_q = mag_r / 32'h0000000A;
	wire [31:0] dec_m = mag_r - dec_q * 32'h0000000A;
	wire [3:0] dig = fmt_r[1] ? mag_r[3:0] : dec_m[3:0];
	wire [7:0] dig_chr = (dig < 4'hA) ? {4'h3, dig} : {4'h0, dig} + 8'h37;
	wire is_pt = fixed_r && dec_r != 4'h0 && dec_r < wid_r && pos == pt_pos;
	wire is_sign = fmt_r[0] && pos == 4'h0;
	wire [7:0] conv_chr = is_pt ? 8'h2E : is_sign ? (neg_r ? 8'h2D : 8'h2B) : dig_chr;

	// rendered field scratch, written one position per cycle
	always @(posedge clk_sys) begin
		if (st_r[2] && cnt_r != wid_r) begin
			scr_r[pos] <= conv_chr;
		end
	end

	// two-flop synchronisers for the pins, then edge detect
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			sync1_r <= 3'h0;
			sync2_r <= 3'h0;
			nv_prev_r <= 1'b0;
		end else begin
			sync1_r <= {heat_on_pin, heat_crit_pin, new_value_pin};
			sync2_r <= sync1_r;
			nv_prev_r <= sync2_r[0];
		end
	end

	// one-second enable divider
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			sec_cnt_r <= 24'h0;
			sec_tick_r <= 1'b0;
		end else if (sec_cnt_r == SEC_CYCLES - 24'h1) begin
			sec_cnt_r <= 24'h0;
			sec_tick_r <= 1'b1;
		end else begin
			sec_cnt_r <= sec_cnt_r + 24'h1;
			sec_tick_r <= 1'b0;
		end
	end

	// fill level: count of sixteenths strictly exceeded, upper bounds inclusive
	wire [14:0] over;
	genvar g;
	generate
		for (g = 1; g < 16; g = g + 1) begin : g_fill
			wire [31:0] bound = {16'h0, avg_time} * g;
			assign over[g-1] = ({12'h0, avg_cnt, 4'h0} > bound[31:0]) && avg_time != 16'h0;
		end
	endgenerate
	always @* begin
		fill_nxt = 4'h0;
		for (k = 0; k < 15; k = k + 1) begin
			fill_nxt = fill_nxt + {3'h0, over[k]};
		end
	end

	// malfunction supervision on the second enable
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			nv_sec_r <= 4'h0;
			st_sec_r <= 7'h0;
			fault_r <= 1'b0;
			static_r <= 1'b0;
			fill_r <= 4'h0;
		end else begin
			fill_r <= fill_nxt;
			// saturating timer, restarted by each fresh value
			if (new_val) nv_sec_r <= 4'h0;
			else if (sec_tick_r && nv_sec_r != `TFM_NOVAL_S) nv_sec_r <= nv_sec_r + 4'h1;
			if (avg_time < `TFM_AVG_LIMIT_S) begin
				fault_r <= (nv_sec_r == `TFM_NOVAL_S);
			end else begin
				fault_r <= ({avg_cnt, 1'b0} < {1'b0, avg_time});
			end
			// a fault must outlast a full minute to become static
			if (!fault_r) st_sec_r <= 7'h0;
			else if (sec_tick_r && st_sec_r != 7'h7F) st_sec_r <= st_sec_r + 7'h1;
			static_r <= (st_sec_r > `TFM_STATIC_S);
		end
	end

	// status words; unlisted bits stay zero
	wire [31:0] xstat = {18'h0, restart_r, 1'b0, fill_r, 3'h0, static_r, 1'b0,
		sync2_r[2], sync2_r[1], fault_r};
	wire [15:0] cstat = {10'h0, xstat[`TFM_XS_STATIC], 1'b0,
		xstat[`TFM_XS_FILL_LO+3:`TFM_XS_FILL_LO+1], xstat[`TFM_XS_FAULT]};

	// apb slave: one wait state, read data captured in the first access cycle
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= acc & ~pready;
			pslverr <= 1'b0;
			if (acc && !pready) begin
				prdata <= 32'h0;
				if (paddr == `TFM_FIELD_OFF) begin
					prdata <= field_r;
				end else if (paddr == `TFM_VALUE_OFF) begin
					prdata <= value_r;
				end else if (paddr == `TFM_CHECK_OFF) begin
					prdata <= {17'h0, check_r};
				end else if (paddr == `TFM_XSTAT_OFF) begin
					prdata <= xstat;
				end else if (paddr == `TFM_CSTAT_OFF) begin
					prdata <= {16'h0, cstat};
				end else if (paddr == `TFM_LEN_OFF) begin
					prdata <= {23'h0, ~idle, 1'b0, len_r};
				end else if (paddr == `TFM_AVG_OFF) begin
					prdata <= avg_r;
				end else if (paddr != `TFM_CTRL_OFF && paddr != `TFM_TEXT_OFF) begin
					pslverr <= 1'b1; // unmapped address
				end
			end
		end
	end

	// configuration registers
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			field_r <= 32'h0;
			value_r <= 32'h0;
			check_r <= 15'h0;
			avg_r <= 32'h0;
		end else if (wr_take) begin
			if (paddr == `TFM_FIELD_OFF) begin
				field_r <= pwdata & `TFM_FIELD_MASK;
			end else if (paddr == `TFM_VALUE_OFF) begin
				value_r <= pwdata;
			end else if (paddr == `TFM_CHECK_OFF) begin
				check_r <= {pwdata[14:8], 2'h0, pwdata[5:0]};
			end else if (paddr == `TFM_AVG_OFF) begin
				avg_r <= pwdata;
			end
		end
	end

	// formatting and send engine
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			st_r <= S_IDLE;
			len_r <= 7'h0;
			idx_r <= 7'h0;
			pend_r <= 1'b0;
			xacc_r <= 8'h0;
			mag_r <= 32'h0;
			neg_r <= 1'b0;
			cnt_r <= 4'h0;
			wid_r <= 4'h0;
			dec_r <= 4'h0;
			fmt_r <= 2'h0;
			fixed_r <= 1'b0;
			load_r <= 1'b0;
			restart_r <= 1'b1;
			tx_data <= 8'h0;
			tx_valid <= 1'b0;
		end else begin
			case (st_r)
				S_IDLE: begin
					if (text_we) begin
						len_r <= len_r + 7'h1;
					end
					if (wr_take && paddr == `TFM_CTRL_OFF) begin
						// commands are only honoured while idle
						if (pwdata[`TFM_CTRL_CLR_BIT]) begin
							len_r <= 7'h0;
						end else if (pwdata[`TFM_CTRL_FMT_BIT]) begin
							wid_r <= eff_wid;
							dec_r <= is_check ? `TFM_DEF_DEC : eff_dec;
							fmt_r <= eff_fmt;
							fixed_r <= field_r[`TFM_FLD_FIXED_BIT] & ~is_check;
							cnt_r <= 4'h0;
							if (is_check) begin
								idx_r <= {1'b0, check_r[5:0]};
								xacc_r <= 8'h0;
								pend_r <= 1'b0;
								st_r <= S_SCAN;
							end else begin
								// unsigned formats show the raw bits
								neg_r <= eff_fmt[0] & value_r[31];
								mag_r <= (eff_fmt[0] && value_r[31]) ? (32'h0 - value_r) : value_r;
								st_r <= S_CONV;
							end
						end else if (pwdata[`TFM_CTRL_SEND_BIT]) begin
							idx_r <= 7'h0;
							load_r <= 1'b0;
							st_r <= S_SEND;
						end
					end
				end
				S_SCAN: begin
					if (pend_r) xacc_r <= xacc_r ^ rd_data;
					if (idx_r < check_r[14:8]) begin
						idx_r <= idx_r + 7'h1;
						pend_r <= 1'b1;
					end else begin
						pend_r <= 1'b0;
						if (!pend_r) begin
							neg_r <= 1'b0;
							mag_r <= {24'h0, xacc_r};
							st_r <= S_CONV;
						end
					end
				end
				S_CONV: begin
					if (cnt_r == wid_r) begin
						cnt_r <= 4'h0;
						st_r <= S_EMIT;
					end else begin
						cnt_r <= cnt_r + 4'h1;
						if (!is_pt && !is_sign) begin
							mag_r <= fmt_r[1] ? {4'h0, mag_r[31:4]} : dec_q;
						end
					end
				end
				S_EMIT: begin
					if (cnt_r == wid_r) begin
						st_r <= S_IDLE;
					end else begin
						cnt_r <= cnt_r + 4'h1;
						if (room) len_r <= len_r + 7'h1;
					end
				end
				S_SEND: begin
					if (tx_valid) begin
						if (tx_ready) tx_valid <= 1'b0;
					end else if (load_r) begin
						tx_data <= rd_data;
						tx_valid <= 1'b1;
						load_r <= 1'b0;
						idx_r <= idx_r + 7'h1;
					end else if (idx_r < len_r) begin
						load_r <= 1'b1;
					end else begin
						restart_r <= 1'b0;
						st_r <= S_IDLE;
					end
				end
				default: begin
					st_r <= S_IDLE;
				end
			endcase
		end
	end
endmodule // tfm_formatter

// ---- tb/tfm_chk.sv ----
`timescale 1ns/1ps
// port-level checks on the apb side and the character stream
module tfm_chk (
	input wire clk_sys,
	input wire reset_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire tx_valid,
	input wire tx_ready,
	input wire [7:0] tx_data
);
	// a read completing this cycle
	wire rd_done = psel && penable && pready && !pwrite;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	property p_rsv;
		rd_done && paddr == 8'h14 |-> (prdata & 32'hFFFFD0E8) == 32'h0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved status bit set");
	property p_cst;
		rd_done && paddr == 8'h18 |-> prdata[31:6] == 26'h0;
	endproperty
	a_cst: assert property (p_cst) else $error("condensed status too wide");
	property p_ctl;
		rd_done && paddr == 8'h00 |-> prdata == 32'h0;
	endproperty
	a_ctl: assert property (p_ctl) else $error("control read not zero");
	property p_wait;
		psel && !penable |=> !pready ##1 pready;
	endproperty
	a_wait: assert property (p_wait) else $error("pready not after one wait state");
	property p_one;
		pready |=> !pready;
	endproperty
	a_one: assert property (p_one) else $error("pready longer than one cycle");
	property p_err;
		pready && paddr > 8'h20 |-> pslverr;
	endproperty
	a_err: assert property (p_err) else $error("unmapped access without error");
	property p_ok;
		pready && paddr <= 8'h20 && paddr[1:0] == 2'h0 |-> !pslverr;
	endproperty
	a_ok: assert property (p_ok) else $error("mapped access flagged");
	property p_hold;
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
	endproperty
	a_hold: assert property (p_hold) else $error("character dropped before take");
	property p_gap;
		tx_valid && tx_ready |=> !tx_valid;
	endproperty
	a_gap: assert property (p_gap) else $error("no gap after take");
	property p_rst;
		disable iff (1'b0) !reset_n |=> !tx_valid && !pready;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs active in reset");
endmodule // tfm_chk

// ---- tb/tfm_host.sv ----
`timescale 1ns/1ps
// serial host stand-in: accepts characters, stalls when told to
module tfm_host (
	input wire clk_sys,
	input wire reset_n,
	input wire stall,
	output logic tx_ready
);
	// ready only out of reset; random stalls stress the hold logic
	always @(posedge clk_sys) begin
		tx_ready <= reset_n && !stall;
	end
endmodule // tfm_host

// ---- tb/tfm_formatter_test.sv ----
`timescale 1ns/1ps
`include "tfm_map.vh"
module tfm_formatter_test;
	logic clk_sys = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, chk_on = 0;
	logic heat_crit_pin = 0, heat_on_pin = 0, new_value_pin = 0, stall = 0, quiet = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rnd = 32'h37, q;
	wire [31:0] prdata;
	wire pready, pslverr, tx_ready, tx_valid;
	wire [7:0] tx_data;
	int err_count = 0, checked = 0, cyc = 0;
	logic [31:0] eq[$], mq[$]; // expected read data and care masks
	logic [7:0] cq[$]; // expected telegram characters
	always #50 clk_sys = ~clk_sys;
	tfm_formatter #(.SEC_CYCLES(24'h00000A)) i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .new_value_pin(new_value_pin),
		.heat_crit_pin(heat_crit_pin), .heat_on_pin(heat_on_pin), .tx_ready(tx_ready),
		.tx_data(tx_data), .tx_valid(tx_valid));
	tfm_host i_host (.clk_sys(clk_sys), .reset_n(reset_n), .stall(stall), .tx_ready(tx_ready));
	function automatic [31:0] xs(input [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task final_report;
		$display("errors %0d checks %0d", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task cmp_reg(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
		checked++;
		if ((g & m) !== (e & m)) begin
			err_count++;
			$display("wrong value %0t reg got %h exp %h", $time, g, e);
		end
	endtask
	task cmp_chr(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %0t char got %h exp %h", $time, g, e);
		end
	endtask
	// random stalls and measurement pulses; values keep arriving unless quiet is set
	always @(posedge clk_sys) begin
		cyc++;
		rnd <= xs(rnd);
		stall <= rnd[0] & rnd[1];
		new_value_pin <= rnd[5] & !quiet; // quiet starves the value timer
		if (cyc == 30000) begin
			err_count++;
			final_report;
		end
	end
	// result watcher: oldest note against each appearing result
	always @(posedge clk_sys) begin
		if (reset_n && tx_valid === 1'b1 && tx_ready === 1'b1) begin
			if (cq.size() == 0)
				cmp_chr(tx_data, 8'hXX);
			else
				cmp_chr(tx_data, cq.pop_front());
		end
		if (chk_on && psel && penable && pready === 1'b1)
			cmp_reg(prdata, eq.pop_front(), mq.pop_front());
	end
	// one apb transfer, entered just after a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
		int n;
		n = 0;
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; chk_on <= c;
		@(posedge clk_sys) penable <= 1;
		@(posedge clk_sys);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge clk_sys);
		end
		if (n == 50) err_count++;
		q = prdata;
		psel <= 0; penable <= 0; chk_on <= 0;
		@(posedge clk_sys);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1, a, d, 0);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		eq.push_back(e);
		mq.push_back(m);
		apb(0, a, 32'h0, 1);
	endtask
	// poll until the busy flag drops, bounded
	task idle;
		int n;
		n = 0;
		do begin
			apb(0, `TFM_LEN_OFF, 32'h0, 0);
			n++;
		end while (q[8] !== 1'b0 && n < 100);
	endtask
	task exp(input string s);
		foreach (s[i]) cq.push_back(s[i]);
	endtask
	task txt(input string s);
		foreach (s[i]) wr(`TFM_TEXT_OFF, {24'h0, s[i]});
		exp(s);
	endtask
	task fmt(input logic [31:0] f, input logic [31:0] v, input string s);
		wr(`TFM_FIELD_OFF, f);
		wr(`TFM_VALUE_OFF, v);
		exp(s);
		wr(`TFM_CTRL_OFF, 32'h1);
		idle;
	endtask
	initial begin
		int n;
		repeat (12) @(posedge clk_sys);
		reset_n <= 1;
		@(posedge clk_sys);
		rd(`TFM_XSTAT_OFF, 32'h2000, 32'hFFFFFFEE);
		rd(`TFM_CTRL_OFF, 32'h0, 32'hFFFFFFFF);
		apb(0, 8'h40, 32'h0, 0);
		wr(`TFM_CTRL_OFF, 32'h4);
		txt("AABBCC");
		wr(`TFM_CHECK_OFF, 32'h0402);
		fmt(32'h00520218, 32'h0, "00");
		wr(`TFM_CHECK_OFF, 32'h0302);
		fmt(32'h00520218, 32'h0, "42");
		fmt(32'h00000005, 32'h5, "005");
		fmt(32'h00510405, 32'hFFFFFFF4, "-012");
		fmt(32'h00530405, 32'hFF, "+0FF");
		fmt(32'h00F12607, 32'h4D2, "+12.34");
		fmt(32'h00800007, 32'h7, "007");
		wr(`TFM_TEXT_OFF, 32'h00013044);
		exp("\015");
		rd(`TFM_LEN_OFF, 32'h1F, 32'h1FF);
		wr(`TFM_CTRL_OFF, 32'h2);
		n = 0;
		while (cq.size() != 0 && n < 3000) begin
			n++;
			@(posedge clk_sys);
		end
		if (n == 3000) err_count++; // telegram never fully sent
		idle;
		rd(`TFM_XSTAT_OFF, 32'h0, 32'hFFFFFFEE);
		heat_crit_pin <= 1;
		wr(`TFM_AVG_OFF, 32'h00080010);
		repeat (6) @(posedge clk_sys);
		rd(`TFM_XSTAT_OFF, 32'h702, 32'hFFFFFFFF);
		rd(`TFM_CSTAT_OFF, 32'h6, 32'hFFFFFFFF);
		heat_on_pin <= 1;
		wr(`TFM_AVG_OFF, 32'h00070010);
		repeat (6) @(posedge clk_sys);
		rd(`TFM_XSTAT_OFF, 32'h607, 32'hFFFFFFFF);
		rd(`TFM_CSTAT_OFF, 32'h7, 32'hFFFFFFFF);
		// fault held past one minute of second ticks becomes static
		repeat (700) @(posedge clk_sys);
		rd(`TFM_XSTAT_OFF, 32'h617, 32'hFFFFFFFF);
		rd(`TFM_CSTAT_OFF, 32'h27, 32'hFFFFFFFF);
		// short averaging: fault only when values stop for ten seconds
		wr(`TFM_AVG_OFF, 32'h00000005);
		repeat (6) @(posedge clk_sys);
		rd(`TFM_XSTAT_OFF, 32'h6, 32'hFFFFFFFF);
		quiet <= 1;
		repeat (150) @(posedge clk_sys);
		rd(`TFM_XSTAT_OFF, 32'h7, 32'hFFFFFFFF);
		quiet <= 0;
		// a second restart must raise the restart flag again
		reset_n <= 0;
		repeat (3) @(posedge clk_sys);
		reset_n <= 1;
		@(posedge clk_sys);
		rd(`TFM_XSTAT_OFF, 32'h2000, 32'hFFFFFFF9);
		final_report;
	end
endmodule // tfm_formatter_test
bind tfm_formatter tfm_chk i_chk (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));
